// *** hw/mpurb_top.sv ***
`timescale 1ns/1ps
module mpurb_top
  import mpurb_pkg::*;
#(
  parameter int NUM_REGIONS = MPURB_REGIONS
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Coprocessor transfer
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic cp_priv,
  input wire logic [3:0] cp_num,
  input wire logic [2:0] cp_opc1,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic [31:0] cp_wdata,
  // Coprocessor answer
  output logic cp_ack,
  output logic cp_undef,
  output logic [31:0] cp_rdata,
  // Address check
  input wire logic [31:0] chk_addr,
  output logic chk_hit,
  output logic [3:0] chk_region
);
  localparam int NR = (NUM_REGIONS > 0) ? NUM_REGIONS : 1;
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  wire logic rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  mpurb_sel_t sel;
  mpurb_decode u_decode (
    .cp_num(cp_num),
    .opc1(cp_opc1),
    .crn(cp_crn),
    .crm(cp_crm),
    .opc2(cp_opc2),
    .sel(sel)
  );

  logic [31:0] base_reg [NR];
  logic [31:0] size_reg [NR];
  logic [3:0] number_reg;
  logic cp_ack_reg;
  logic cp_undef_reg;
  logic [31:0] cp_rdata_reg;
  logic chk_hit_reg;
  logic [3:0] chk_region_reg;

  wire logic present;
  wire logic allowed;
  wire logic wr_base;
  wire logic wr_size;
  wire logic wr_number;
  wire logic [31:0] rd_value;
  wire logic [31:0] cur_base;
  wire logic [31:0] cur_size;
  assign present = (NUM_REGIONS > 0);
  assign allowed = cp_valid && cp_priv && present && (sel != MPURB_SEL_NONE);
  assign wr_base = allowed && cp_write && (sel == MPURB_SEL_BASE);
  assign wr_size = allowed && cp_write && (sel == MPURB_SEL_SIZE);
  assign wr_number = allowed && cp_write && (sel == MPURB_SEL_NUMBER);
  assign cur_base = base_reg[number_reg];
  assign cur_size = size_reg[number_reg];
  assign rd_value = (sel == MPURB_SEL_BASE) ? (cur_base & MPURB_BASE_MASK) :
                    (sel == MPURB_SEL_SIZE) ? (cur_size & MPURB_SIZE_MASK) :
                    (sel == MPURB_SEL_NUMBER) ? {28'h0000000, number_reg} : 32'h00000000;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      number_reg <= MPURB_NUMBER_RST;
    end else if (wr_number) begin
      number_reg <= 4'(cp_wdata & MPURB_NUMBER_MASK);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NR; g++) begin : g_region
      always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
          base_reg[g] <= MPURB_BASE_RST;
          size_reg[g] <= MPURB_SIZE_RST;
        end else begin
          if (wr_base && number_reg == 4'(g)) begin
            base_reg[g] <= cp_wdata & MPURB_BASE_MASK;
          end
          if (wr_size && number_reg == 4'(g)) begin
            size_reg[g] <= cp_wdata & MPURB_SIZE_MASK;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_ack_reg <= 1'b0;
      cp_undef_reg <= 1'b0;
      cp_rdata_reg <= 32'h00000000;
    end else begin
      cp_ack_reg <= allowed;
      cp_undef_reg <= cp_valid && !allowed;
      cp_rdata_reg <= (allowed && !cp_write) ? rd_value : 32'h00000000;
    end
  end

  logic [NR-1:0] hits;
  generate
    for (g = 0; g < NR; g++) begin : g_match
      mpurb_match u_match (
        .base(base_reg[g]),
        .size_en(size_reg[g]),
        .addr(chk_addr),
        .hit(hits[g])
      );
    end
  endgenerate

  logic any_hit;
  logic [3:0] top_idx;
  always_comb begin
    any_hit = 1'b0;
    top_idx = 4'h0;
    for (int i = 0; i < NR; i++) begin
      if (hits[i]) begin
        any_hit = present;
        top_idx = 4'(i);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      chk_hit_reg <= 1'b0;
      chk_region_reg <= 4'h0;
    end else begin
      chk_hit_reg <= any_hit;
      chk_region_reg <= top_idx;
    end
  end

  assign cp_ack = cp_ack_reg;
  assign cp_undef = cp_undef_reg;
  assign cp_rdata = cp_rdata_reg;
  assign chk_hit = chk_hit_reg;
  assign chk_region = chk_region_reg;
endmodule

// *** hw/mpurb_pkg.sv ***
package mpurb_pkg;
  localparam int MPURB_REGIONS = 12;
  localparam int MPURB_IDX_W = 4;
  localparam logic [3:0] MPURB_CP_NUM = 4'hf;
  localparam logic [2:0] MPURB_OPC1 = 3'h0;
  localparam logic [3:0] MPURB_CRN = 4'h6;
  localparam logic [3:0] MPURB_CRM_REGION = 4'h1;
  localparam logic [3:0] MPURB_CRM_NUMBER = 4'h2;
  localparam logic [2:0] MPURB_OPC2_BASE = 3'h0;
  localparam logic [2:0] MPURB_OPC2_SIZE = 3'h2;
  localparam logic [2:0] MPURB_OPC2_NUMBER = 3'h0;
  localparam logic [31:0] MPURB_BASE_MASK = 32'hffffffe0;
  localparam logic [31:0] MPURB_SIZE_MASK = 32'h0000ff3f;
  localparam logic [31:0] MPURB_NUMBER_MASK = 32'h0000000f;
  localparam int MPURB_SIZE_LSB = 1;
  localparam int MPURB_SUB_LSB = 8;
  localparam int MPURB_EN_BIT = 0;
  localparam logic [4:0] MPURB_SIZE_MIN_CODE = 5'h04;
  localparam logic [31:0] MPURB_BASE_RST = 32'h00000000;
  localparam logic [31:0] MPURB_SIZE_RST = 32'h00000000;
  localparam logic [3:0] MPURB_NUMBER_RST = 4'h0;
  typedef enum {MPURB_SEL_NONE, MPURB_SEL_BASE, MPURB_SEL_SIZE, MPURB_SEL_NUMBER} mpurb_sel_t;
endpackage

// *** hw/mpurb_decode.sv ***
`timescale 1ns/1ps
module mpurb_decode
  import mpurb_pkg::*;
(
  // Coprocessor instruction fields
  input wire logic [3:0] cp_num,
  input wire logic [2:0] opc1,
  input wire logic [3:0] crn,
  input wire logic [3:0] crm,
  input wire logic [2:0] opc2,
  // Decoded target
  output mpurb_sel_t sel
);
  wire logic common_hit;
  assign common_hit = (cp_num == MPURB_CP_NUM) && (opc1 == MPURB_OPC1) && (crn == MPURB_CRN);
  always_comb begin
    sel = MPURB_SEL_NONE;
    if (common_hit && crm == MPURB_CRM_REGION && opc2 == MPURB_OPC2_BASE) begin
      sel = MPURB_SEL_BASE;
    end else if (common_hit && crm == MPURB_CRM_REGION && opc2 == MPURB_OPC2_SIZE) begin
      sel = MPURB_SEL_SIZE;
    end else if (common_hit && crm == MPURB_CRM_NUMBER && opc2 == MPURB_OPC2_NUMBER) begin
      sel = MPURB_SEL_NUMBER;
    end
  end
endmodule

// *** hw/mpurb_match.sv ***
`timescale 1ns/1ps
module mpurb_match
  import mpurb_pkg::*;
(
  // Region setup
  input wire logic [31:0] base,
  input wire logic [31:0] size_en,
  // Address under check
  input wire logic [31:0] addr,
  // Result
  output logic hit
);
  wire logic [4:0] code;
  wire logic [5:0] log2_size;
  wire logic [32:0] span;
  wire logic [32:0] offset;
  wire logic [32:0] lo_mask;
  wire logic in_range;
  wire logic [2:0] sub_idx;
  wire logic [7:0] sub_dis;
  assign code = size_en[MPURB_SIZE_LSB +: 5];
  assign sub_dis = size_en[MPURB_SUB_LSB +: 8];
  assign log2_size = {1'b0, code} + 6'h01;
  assign span = 33'h1 << log2_size;
  assign lo_mask = span - 33'h1;
  assign offset = {1'b0, addr} - {1'b0, base[31:5], 5'h00};
  assign in_range = (offset < span) && (addr >= {base[31:5], 5'h00});
  assign sub_idx = 3'((offset & lo_mask) >> (log2_size - 6'h03));
  always_comb begin
    hit = size_en[MPURB_EN_BIT] && in_range && !sub_dis[sub_idx];
  end
endmodule

// *** testbench/mpurb_top_monitor.sv ***
`timescale 1ns/1ps
module mpurb_top_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Transfer
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic cp_priv,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_opc2,
  input wire logic cp_ack,
  input wire logic cp_undef,
  input wire logic [31:0] cp_rdata,
  // Check
  input wire logic chk_hit,
  input wire logic [3:0] chk_region
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_user;
    cp_valid && !cp_priv;
  endsequence
  sequence s_nohit;
    !chk_hit ##1 !chk_hit;
  endsequence
  property p_answer; cp_valid |=> cp_ack != cp_undef; endproperty
  property p_idle; !cp_valid |=> !cp_ack && !cp_undef; endproperty
  property p_user; s_user |=> cp_undef; endproperty
  property p_wrdata; cp_valid && cp_write |=> cp_rdata == 32'h0; endproperty
  property p_high; cp_valid && !cp_write && cp_crm == 4'h1 && cp_opc2 == 3'h2 |=> cp_rdata[31:16] == 16'h0; endproperty
  property p_basel; cp_valid && !cp_write && cp_crm == 4'h1 && cp_opc2 == 3'h0 |=> cp_rdata[4:0] == 5'h00; endproperty
  property p_undef; cp_undef |-> cp_rdata == 32'h0; endproperty
  property p_region; !chk_hit |-> chk_region == 4'h0; endproperty
  property p_reset; $rose(nrst) |-> s_nohit; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_user: assert property (p_user) else $error("user access taken");
  a_wrdata: assert property (p_wrdata) else $error("read data on write");
  a_high: assert property (p_high) else $error("reserved bits set");
  a_basel: assert property (p_basel) else $error("base low bits set");
  a_undef: assert property (p_undef) else $error("data on refusal");
  a_region: assert property (p_region) else $error("region without hit");
  a_reset: assert property (p_reset) else $error("hit after reset");
endmodule
bind mpurb_top mpurb_top_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .cp_valid(cp_valid),
  .cp_write(cp_write), .cp_priv(cp_priv), .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_ack(cp_ack),
  .cp_undef(cp_undef), .cp_rdata(cp_rdata),
  .chk_hit(chk_hit), .chk_region(chk_region));

// *** testbench/mpurb_top_bench.sv ***
`timescale 1ns/1ps
module mpurb_top_bench;
  logic ref_clk = 0, nrst = 0, cp_valid = 0, cp_write = 0, cp_priv = 0, cp_ack, cp_undef, chk_hit;
  logic [3:0] cp_crn = 4'h6, cp_crm = 4'h1, chk_region;
  logic [2:0] cp_opc2 = 3'h0;
  logic [31:0] cp_wdata = 32'h0, chk_addr = 32'h0, cp_rdata;
  int fails = 0, n_tests = 0, cyc = 0;
  mpurb_top dut (.ref_clk(ref_clk), .nrst(nrst), .cp_valid(cp_valid), .cp_write(cp_write), .cp_priv(cp_priv),
    .cp_num(4'hf), .cp_opc1(3'h0), .cp_crn(cp_crn), .cp_crm(cp_crm), .cp_opc2(cp_opc2), .cp_wdata(cp_wdata),
    .cp_ack(cp_ack), .cp_undef(cp_undef), .cp_rdata(cp_rdata), .chk_addr(chk_addr), .chk_hit(chk_hit),
    .chk_region(chk_region));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic finish_test();
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fails++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Target 0 base, 1 size/enable, 2 selector, 3 undecoded
  task automatic cp(input logic w, input logic p, input logic u, input int t, input logic [31:0] d);
    cp_valid <= 1;
    cp_write <= w;
    cp_priv <= p;
    cp_wdata <= d;
    cp_crn <= (t == 3) ? 4'h5 : 4'h6;
    cp_crm <= (t == 2) ? 4'h2 : 4'h1;
    cp_opc2 <= (t == 1) ? 3'h2 : 3'h0;
    @(posedge ref_clk);
    cp_valid <= 0;
    #1;
    chk({31'h0, cp_undef}, {31'h0, u});
    if (!w)
      chk(cp_rdata, d);
  endtask
  task automatic hit(input logic [31:0] a, input logic h, input logic [3:0] g);
    chk_addr <= a;
    @(posedge ref_clk);
    #1;
    chk({31'h0, chk_hit}, {31'h0, h});
    chk({28'h0, chk_region}, {28'h0, g});
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    nrst <= 1;
    repeat (3) @(posedge ref_clk);
    cp(0, 1, 0, 1, 32'h0);
    cp(1, 1, 0, 0, 32'h1234567f);
    cp(0, 1, 0, 0, 32'h12345660);
    cp(1, 1, 0, 1, 32'hffffff3e);
    cp(0, 1, 0, 1, 32'h0000ff3e);
    cp(1, 1, 0, 2, 32'h00000011);
    cp(0, 1, 0, 2, 32'h00000001);
    cp(0, 1, 0, 0, 32'h0);
    cp(1, 0, 1, 0, 32'hffffffe0);
    cp(0, 1, 0, 0, 32'h0);
    cp(0, 1, 1, 3, 32'h0);
    cp(1, 1, 0, 2, 32'h2);
    cp(1, 1, 0, 0, 32'h1000);
    cp(1, 1, 0, 1, 32'h020f);
    hit(32'h1010, 1, 2);
    hit(32'h1030, 0, 0);
    hit(32'h10ff, 1, 2);
    hit(32'h1100, 0, 0);
    hit(32'h0ff0, 0, 0);
    cp(1, 1, 0, 1, 32'h020e);
    hit(32'h1010, 0, 0);
    finish_test();
  end
endmodule
